// *** logic/spc_top.sv ***
// Stall-prevention and flux-braking supervisor with an AHB-Lite register slave.
`timescale 1ns/1ps
`default_nettype none
`include "spc_cfg.svh"
module spc_top import spc_pkg::*; #(
   parameter int FREQ_W = 16,
   parameter int CUR_W  = 8,
   parameter int DC_W   = 12,
   parameter int CYCLES = `SPC_CTRL_CYCLES
) (
   input  wire logic              clock,
   input  wire logic              srst,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output var  logic [31:0]       hrdata,
   output var  logic              hreadyout,
   output var  logic              hresp,
   input  wire logic              motor_run,
   input  wire logic [FREQ_W-1:0] target_freq,
   input  wire logic [CUR_W-1:0]  current_pct,
   input  wire logic [DC_W-1:0]   dc_link,
   output var  logic [FREQ_W-1:0] out_freq_q,
   output var  logic              flux_brake_q,
   output var  logic              stall_active_q,
   output var  logic [3:0]        keypad_seg_q
);
   logic [3:0]        sel_q;
   logic [CUR_W-1:0]  level_q;
   logic [FREQ_W-1:0] start_q;
   logic [DC_W-1:0]   dclim_q;
   logic [FREQ_W-1:0] acc_step_q;
   logic [FREQ_W-1:0] dec_step_q;
   logic              wr_q;
   logic [`SPC_ADDR_W-1:0] wadr_q;
   spc_state_t        state_q;
   spc_state_t        state_d;
   logic [FREQ_W-1:0] freq_d;
   logic [FREQ_W-1:0] lower_f;
   logic [FREQ_W-1:0] raise_f;
   logic [FREQ_W-1:0] ramp_dn;
   logic [FREQ_W-1:0] dstep;
   logic              accel;
   logic              steady;
   logic              decel;

   spc_sense_if #(.CUR_W(CUR_W), .DC_W(DC_W)) sense ();

   spc_tick #(.CYCLES(CYCLES)) u_tick (
      .clock  (clock),
      .srst   (srst),
      .tick_q (sense.tick)
   );

   spc_detect u_det (
      .clock (clock),
      .srst  (srst),
      .s     (sense)
   );

   // Sense inputs and the stall level feed the detector at all times, whether or not the motor runs.
   assign sense.current_pct = current_pct;
   assign sense.level_pct   = level_q;
   assign sense.dc_link     = dc_link;
   assign sense.dc_limit    = dclim_q;

   // The slave never inserts wait states and always answers OKAY.
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // Address phase capture for writes.
   always_ff @(posedge clock) begin
      if (srst) begin
         wr_q   <= 1'b0;
         wadr_q <= 8'h00;
      end else if (hready) begin
         wr_q   <= hsel && htrans[1] && hwrite;
         wadr_q <= haddr[`SPC_ADDR_W-1:0];
      end
   end

   // Data phase writes into the configuration registers.
   always_ff @(posedge clock) begin
      if (srst) begin
         sel_q      <= `SPC_RST_SELECT;
         level_q    <= `SPC_RST_LEVEL;
         start_q    <= `SPC_RST_START;
         dclim_q    <= `SPC_RST_DCLIM;
         acc_step_q <= `SPC_RST_ACC_STEP;
         dec_step_q <= `SPC_RST_DEC_STEP;
      end else if (wr_q) begin
         case (wadr_q)
            `SPC_OFS_SELECT: sel_q <= hwdata[3:0];
            `SPC_OFS_LEVEL:  level_q <= hwdata[CUR_W-1:0];
            `SPC_OFS_START:  start_q <= hwdata[FREQ_W-1:0];
            `SPC_OFS_DCLIM:  dclim_q <= hwdata[DC_W-1:0];
            `SPC_OFS_STEPS: begin
               acc_step_q <= hwdata[FREQ_W-1:0];
               dec_step_q <= hwdata[`SPC_DEC_LSB+FREQ_W-1:`SPC_DEC_LSB];
            end
            default: ;
         endcase
      end
   end

   // Read data is registered in the address phase; unmapped words read zero.
   always_ff @(posedge clock) begin
      if (srst) begin
         hrdata <= 32'h0000_0000;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         case (haddr[`SPC_ADDR_W-1:0])
            `SPC_OFS_SELECT: hrdata <= 32'(sel_q);
            `SPC_OFS_LEVEL:  hrdata <= 32'(level_q);
            `SPC_OFS_START:  hrdata <= 32'(start_q);
            `SPC_OFS_DCLIM:  hrdata <= 32'(dclim_q);
            `SPC_OFS_STEPS:  hrdata <= {16'(dec_step_q), 16'(acc_step_q)};
            `SPC_OFS_STATUS: hrdata <= {8'h00, 16'(out_freq_q), 1'b0, sense.dc_high, sense.over,
                                        flux_brake_q, stall_active_q, 1'b0, 2'(state_q)};
            `SPC_OFS_KEYPAD: hrdata <= 32'(keypad_seg_q);
            default:         hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // Ramp direction relative to the target.
   assign accel  = out_freq_q < target_freq;
   assign steady = out_freq_q == target_freq;
   assign decel  = out_freq_q > target_freq;

   // Flux braking doubles the down step while decelerating.
   assign dstep = sel_q[`SPC_BIT_FLUX] ? FREQ_W'({dec_step_q, 1'b0}) : dec_step_q;

   // Candidate frequencies: stall lowering floors at the start frequency, raising caps at the target.
   always_comb begin
      if (out_freq_q <= start_q) begin
         lower_f = out_freq_q;
      end else if (out_freq_q - start_q > dec_step_q) begin
         lower_f = out_freq_q - dec_step_q;
      end else begin
         lower_f = start_q;
      end
      if (target_freq - out_freq_q > acc_step_q) begin
         raise_f = out_freq_q + acc_step_q;
      end else begin
         raise_f = target_freq;
      end
      if (out_freq_q - target_freq > dstep) begin
         ramp_dn = out_freq_q - dstep;
      end else begin
         ramp_dn = target_freq;
      end
   end

   // Supervisor decisions, taken once per control cycle; a stop (motor_run low) acts in any clock cycle.
   always_comb begin
      state_d = state_q;
      freq_d  = out_freq_q;
      if (!motor_run) begin
         state_d = SPC_ST_STOP;
         freq_d  = '0;
      end else if (sense.tick) begin
         case (state_q)
            SPC_ST_STOP: begin
               state_d = SPC_ST_RUN;
            end
            SPC_ST_RUN: begin
               if (accel && sel_q[`SPC_BIT_ACC] && sense.over) begin
                  state_d = SPC_ST_ACC_STALL;
                  freq_d  = lower_f;
               end else if (steady && sel_q[`SPC_BIT_CONST] && sense.over) begin
                  state_d = SPC_ST_CONST_STALL;
                  freq_d  = lower_f;
               end else if (accel) begin
                  freq_d = raise_f;
               end else if (decel && !(sel_q[`SPC_BIT_DEC] && sense.dc_high)) begin
                  freq_d = ramp_dn;
               end
            end
            SPC_ST_ACC_STALL, SPC_ST_CONST_STALL: begin
               if (sense.over) begin
                  freq_d = lower_f;
               end else if (accel) begin
                  freq_d = raise_f;
               end else begin
                  state_d = SPC_ST_RUN;
               end
            end
            default: begin
               state_d = SPC_ST_STOP;
            end
         endcase
      end
   end

   // State and frequency registers.
   always_ff @(posedge clock) begin
      if (srst) begin
         state_q    <= SPC_ST_STOP;
         out_freq_q <= '0;
      end else begin
         state_q    <= state_d;
         out_freq_q <= freq_d;
      end
   end

   // Status outputs; flux braking only while decelerating, alongside deceleration stall.
   always_ff @(posedge clock) begin
      if (srst) begin
         flux_brake_q   <= 1'b0;
         stall_active_q <= 1'b0;
         keypad_seg_q   <= ~`SPC_RST_SELECT;
      end else begin
         flux_brake_q   <= motor_run && decel && sel_q[`SPC_BIT_FLUX];
         stall_active_q <= (state_d == SPC_ST_ACC_STALL) || (state_d == SPC_ST_CONST_STALL)
                           || (decel && sel_q[`SPC_BIT_DEC] && sense.dc_high);
         keypad_seg_q   <= ~sel_q;
      end
   end

   // Checks of the supervisor behaviour.
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   sequence s_high_tick;
      motor_run && sense.tick && sense.over;
   endsequence
   sequence s_low_tick;
      motor_run && sense.tick && !sense.over && accel;
   endsequence

   property p_acc_stall;
      (s_high_tick and (state_q == SPC_ST_RUN && accel && sel_q[`SPC_BIT_ACC] && out_freq_q > start_q))
         |=> out_freq_q < $past(out_freq_q) ##0 state_q == SPC_ST_ACC_STALL;
   endproperty
   a_acc_stall: assert property (p_acc_stall) else $error("Acceleration stall missed.");

   property p_floor;
      (state_q == SPC_ST_ACC_STALL && out_freq_q >= start_q && motor_run) |=> out_freq_q >= $past(start_q);
   endproperty
   a_floor: assert property (p_floor) else $error("Frequency fell below start.");

   property p_acc_resume;
      (s_low_tick and state_q == SPC_ST_ACC_STALL) |=> out_freq_q > $past(out_freq_q);
   endproperty
   a_acc_resume: assert property (p_acc_resume) else $error("No resume after stall.");

   property p_const_stall;
      (s_high_tick and (state_q == SPC_ST_RUN && steady && sel_q[`SPC_BIT_CONST]
                        && !sel_q[`SPC_BIT_ACC] && out_freq_q > start_q))
         |=> state_q == SPC_ST_CONST_STALL ##0 out_freq_q < $past(out_freq_q);
   endproperty
   a_const_stall: assert property (p_const_stall) else $error("Constant stall missed.");

   property p_const_resume;
      (s_low_tick and state_q == SPC_ST_CONST_STALL) |=> out_freq_q > $past(out_freq_q);
   endproperty
   a_const_resume: assert property (p_const_resume) else $error("No rise after reduction.");

   property p_dec_hold;
      (motor_run && sense.tick && state_q == SPC_ST_RUN && decel && sel_q[`SPC_BIT_DEC] && sense.dc_high)
         |=> $stable(out_freq_q);
   endproperty
   a_dec_hold: assert property (p_dec_hold) else $error("Ramp ignored link limit.");

   property p_flux_on;
      (motor_run && decel && sel_q[`SPC_BIT_FLUX]) |=> flux_brake_q;
   endproperty
   a_flux_on: assert property (p_flux_on) else $error("Flux braking missing.");

   property p_flux_only_dec;
      flux_brake_q |-> $past(decel) && $past(sel_q[`SPC_BIT_FLUX]);
   endproperty
   a_flux_only_dec: assert property (p_flux_only_dec) else $error("Flux braking outside deceleration.");

   property p_keypad;
      ##1 keypad_seg_q == ~$past(sel_q);
   endproperty
   a_keypad: assert property (p_keypad) else $error("Keypad not inverted.");

   property p_level;
      sense.tick |=> sense.over == ($past(current_pct) > $past(level_q));
   endproperty
   a_level: assert property (p_level) else $error("Wrong stall threshold.");
endmodule : spc_top
`default_nettype wire

// *** logic/spc_cfg.svh ***
// Register map, reset values and timing constants of the stall-prevention supervisor.
`ifndef SPC_CFG_SVH
`define SPC_CFG_SVH
`define SPC_ADDR_W        8
`define SPC_OFS_SELECT    8'h00
`define SPC_OFS_LEVEL     8'h04
`define SPC_OFS_START     8'h08
`define SPC_OFS_DCLIM     8'h0c
`define SPC_OFS_STEPS     8'h10
`define SPC_OFS_STATUS    8'h14
`define SPC_OFS_KEYPAD    8'h18
`define SPC_RST_SELECT    4'h0
`define SPC_RST_LEVEL     8'hb4
`define SPC_RST_START     16'h0032
`define SPC_RST_DCLIM     12'h2ee
`define SPC_RST_ACC_STEP  16'h0001
`define SPC_RST_DEC_STEP  16'h0001
`define SPC_BIT_ACC       0
`define SPC_BIT_CONST     1
`define SPC_BIT_DEC       2
`define SPC_BIT_FLUX      3
`define SPC_DEC_LSB       16
`define SPC_CLK_PERIOD_NS 50
`define SPC_CTRL_PERIOD_NS 1000
`define SPC_CTRL_CYCLES   (`SPC_CTRL_PERIOD_NS / `SPC_CLK_PERIOD_NS)
`endif

// *** logic/spc_pkg.sv ***
// Types shared by the stall-prevention supervisor.
`default_nettype none
package spc_pkg;
   typedef enum logic [1:0] {
      SPC_ST_STOP,
      SPC_ST_RUN,
      SPC_ST_ACC_STALL,
      SPC_ST_CONST_STALL
   } spc_state_t;
endpackage : spc_pkg
`default_nettype wire

// *** logic/spc_sense_if.sv ***
// Sense signals between the supervisor core and its current and link-voltage detector.
`timescale 1ns/1ps
`default_nettype none
interface spc_sense_if #(parameter int CUR_W = 8, parameter int DC_W = 12);
   logic             tick;
   logic [CUR_W-1:0] current_pct;
   logic [CUR_W-1:0] level_pct;
   logic [DC_W-1:0]  dc_link;
   logic [DC_W-1:0]  dc_limit;
   logic             over;
   logic             dc_high;
   modport det  (input tick, current_pct, level_pct, dc_link, dc_limit, output over, dc_high);
   modport core (output tick, current_pct, level_pct, dc_link, dc_limit, input over, dc_high);
endinterface : spc_sense_if
`default_nettype wire

// *** logic/spc_tick.sv ***
// Control-cycle tick generator.
`timescale 1ns/1ps
`default_nettype none
`include "spc_cfg.svh"
module spc_tick #(
   parameter int CYCLES = `SPC_CTRL_CYCLES
) (
   input  wire logic clock,
   input  wire logic srst,
   output var  logic tick_q
);
   logic [15:0] cnt_q;

   // Counts clock cycles and pulses once per control cycle.
   always_ff @(posedge clock) begin
      if (srst) begin
         cnt_q  <= 16'h0000;
         tick_q <= 1'b0;
      end else if (cnt_q == 16'(CYCLES - 1)) begin
         cnt_q  <= 16'h0000;
         tick_q <= 1'b1;
      end else begin
         cnt_q  <= cnt_q + 16'h0001;
         tick_q <= 1'b0;
      end
   end
endmodule : spc_tick
`default_nettype wire

// *** logic/spc_detect.sv ***
// Current and link-voltage comparators, evaluated once per control cycle.
`timescale 1ns/1ps
`default_nettype none
module spc_detect (
   input wire logic clock,
   input wire logic srst,
   spc_sense_if.det s
);
   // Compares current against the stall level and the link against its limit on each tick.
   always_ff @(posedge clock) begin
      if (srst) begin
         s.over    <= 1'b0;
         s.dc_high <= 1'b0;
      end else if (s.tick) begin
         s.over    <= (s.current_pct > s.level_pct);
         s.dc_high <= (s.dc_link >= s.dc_limit);
      end
   end

   property p_over_cmp;
      @(posedge clock) disable iff (srst)
         s.tick |=> s.over == ($past(s.current_pct) > $past(s.level_pct));
   endproperty
   a_over_cmp: assert property (p_over_cmp) else $error("Stall comparison wrong.");
endmodule : spc_detect
`default_nettype wire

// *** logic/spc_pkg_end_marker_unused.sv ***
// Holds no logic of the stall-prevention supervisor.
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// *** verif/spc_motor_model.sv ***
// Behavioural motor and power stage that returns current and link voltage to the supervisor.
`timescale 1ns/1ps
`default_nettype none
module spc_motor_model #(
   parameter logic [11:0] DC_NOMINAL = 12'h200,
   parameter logic [11:0] DC_REGEN   = 12'h2ee
) (
   input  wire logic        clock,
   input  wire logic        srst,
   input  wire logic [7:0]  load_pct,
   input  wire logic        regen,
   input  wire logic [15:0] out_freq,
   output var  logic [7:0]  current_pct,
   output var  logic [11:0] dc_link
);
   // A standing shaft draws no current; a regenerating load lifts the link to its limit.
   always_ff @(posedge clock) begin
      if (srst) begin
         current_pct <= 8'h00;
         dc_link     <= DC_NOMINAL;
      end else begin
         current_pct <= (out_freq == 16'h0000) ? 8'h00 : load_pct;
         dc_link     <= regen ? DC_REGEN : DC_NOMINAL;
      end
   end
endmodule : spc_motor_model
`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench of the stall-prevention supervisor over its register bus.
`timescale 1ns/1ps
`default_nettype none
`include "spc_cfg.svh"
module testbench;
   localparam int CYC = 4;
   logic        clock = 1'b0;
   logic        srst = 1'b1;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        motor_run = 1'b0;
   logic [15:0] target_freq = 16'h0;
   logic [7:0]  current_pct;
   logic [11:0] dc_link;
   logic [15:0] out_freq_q;
   logic        flux_brake_q;
   logic        stall_active_q;
   logic [3:0]  keypad_seg_q;
   logic [7:0]  load_pct = 8'h0;
   logic        regen = 1'b0;
   logic [31:0] rdat;
   logic [15:0] f;
   int          mismatches = 0;
   int          total_checks = 0;
   logic [7:0]  rst_ofs [9] = '{`SPC_OFS_SELECT, `SPC_OFS_LEVEL, `SPC_OFS_START, `SPC_OFS_DCLIM,
                                 `SPC_OFS_STEPS, `SPC_OFS_STATUS, `SPC_OFS_KEYPAD, 8'h1c, 8'h80};
   logic [31:0] rst_exp [9] = '{32'h0, 32'hb4, 32'h32, 32'h2ee, 32'h00010001, 32'h0, 32'hf, 32'h0, 32'h0};
   logic [3:0]  codes [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hc};

   spc_top #(.CYCLES(CYC)) dut (.clock(clock), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .motor_run(motor_run), .target_freq(target_freq),
      .current_pct(current_pct), .dc_link(dc_link), .out_freq_q(out_freq_q), .flux_brake_q(flux_brake_q),
      .stall_active_q(stall_active_q), .keypad_seg_q(keypad_seg_q));

   spc_motor_model motor (.clock(clock), .srst(srst), .load_pct(load_pct), .regen(regen),
      .out_freq(out_freq_q), .current_pct(current_pct), .dc_link(dc_link));

   // The clock toggles every half period of 25 ns.
   always #25 clock = ~clock;

   // Counts one comparison and reports a mismatch at once.
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // One single word transfer: address phase, then data phase, each held until hready.
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clock);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge clock); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clock); while (hreadyout !== 1'b1);
      rdat = hrdata;
   endtask : xfer

   // Reads the status word and compares its state field.
   task automatic state_chk(input logic [1:0] e);
      xfer(`SPC_OFS_STATUS, 1'b0, 32'h0);
      chk("state", {30'h0, e}, {30'h0, rdat[1:0]});
   endtask : state_chk

   // Waits a number of control cycles, ending on a falling edge where outputs are settled.
   task automatic ticks(input int n);
      repeat (n * CYC) @(negedge clock);
   endtask : ticks

   // Waits under a bound for the output frequency to reach a value.
   task automatic wait_freq(input logic [15:0] v);
      int n;
      n = 0;
      while (out_freq_q !== v && n < 4000) begin
         @(negedge clock);
         n++;
      end
      chk("out_freq settle", {16'h0, v}, {16'h0, out_freq_q});
   endtask : wait_freq

   // Aligns to a frequency change, then measures the change over two control cycles.
   task automatic step_chk(input logic [15:0] st);
      logic [15:0] p;
      int          n;
      p = out_freq_q;
      n = 0;
      while (out_freq_q === p && n < 100) begin
         @(negedge clock);
         n++;
      end
      p = out_freq_q;
      repeat (2 * CYC) @(negedge clock);
      chk("two-step fall", {15'h0, st, 1'b0}, {16'h0, p - out_freq_q});
   endtask : step_chk

   // Prints the counts and the verdict, then ends the run.
   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : results

   // Cuts a hang short well beyond the expected run length.
   initial begin
      repeat (20000) @(posedge clock);
      mismatches++;
      results();
   end

   // Main sequence of scenarios.
   initial begin
      repeat (12) @(posedge clock);
      srst <= 1'b0;
      for (int i = 0; i < 9; i++) begin
         xfer(rst_ofs[i], 1'b0, 32'h0);
         chk("reset value", rst_exp[i], rdat);
      end
      chk("hresp", 32'h0, {31'h0, hresp});
      chk("hreadyout", 32'h1, {31'h0, hreadyout});
      xfer(`SPC_OFS_STATUS, 1'b1, 32'hffffffff);
      state_chk(2'h0);
      for (int i = 0; i < 5; i++) begin
         xfer(`SPC_OFS_SELECT, 1'b1, {28'h0, codes[i]});
         xfer(`SPC_OFS_SELECT, 1'b0, 32'h0);
         chk("select", {28'h0, codes[i]}, rdat);
         chk("keypad", {28'h0, ~codes[i]}, {28'h0, keypad_seg_q});
      end
      xfer(`SPC_OFS_LEVEL, 1'b1, 32'd100);
      xfer(`SPC_OFS_START, 1'b1, 32'h10);
      xfer(`SPC_OFS_STEPS, 1'b1, 32'h00040004);
      xfer(`SPC_OFS_SELECT, 1'b1, 32'h1);
      target_freq <= 16'h0100;
      load_pct    <= 8'd50;
      motor_run   <= 1'b1;
      while (out_freq_q < 16'h0040) @(negedge clock);
      @(posedge clock);
      load_pct <= 8'd150;
      ticks(4);
      chk("acc stall flag", 32'h1, {31'h0, stall_active_q});
      state_chk(2'h2);
      f = out_freq_q;
      ticks(2);
      chk("acc stall lowers", 32'h1, {31'h0, out_freq_q < f});
      ticks(40);
      chk("start floor", 32'h10, {16'h0, out_freq_q});
      @(posedge clock);
      load_pct <= 8'd50;
      ticks(4);
      chk("acc resume", 32'h1, {31'h0, out_freq_q > 16'h0010});
      wait_freq(16'h0100);
      xfer(`SPC_OFS_SELECT, 1'b1, 32'h2);
      load_pct <= 8'd100;
      ticks(4);
      chk("level boundary", 32'h100, {16'h0, out_freq_q});
      @(posedge clock);
      load_pct <= 8'd101;
      ticks(4);
      chk("const stall flag", 32'h1, {31'h0, stall_active_q});
      chk("const lowers", 32'h1, {31'h0, out_freq_q < 16'h0100});
      state_chk(2'h3);
      load_pct <= 8'd50;
      wait_freq(16'h0100);
      ticks(2);
      state_chk(2'h1);
      xfer(`SPC_OFS_SELECT, 1'b1, 32'h4);
      regen       <= 1'b1;
      target_freq <= 16'h00c0;
      ticks(4);
      f = out_freq_q;
      ticks(3);
      chk("dec hold", {16'h0, f}, {16'h0, out_freq_q});
      chk("dec hold flag", 32'h1, {31'h0, stall_active_q});
      chk("no flux", 32'h0, {31'h0, flux_brake_q});
      @(posedge clock);
      regen <= 1'b0;
      step_chk(16'h0004);
      wait_freq(16'h00c0);
      xfer(`SPC_OFS_SELECT, 1'b1, 32'h8);
      target_freq <= 16'h0060;
      ticks(2);
      chk("flux on", 32'h1, {31'h0, flux_brake_q});
      step_chk(16'h0008);
      wait_freq(16'h0060);
      ticks(1);
      chk("flux off at target", 32'h0, {31'h0, flux_brake_q});
      // A single combined stop keeps the motor cool; repeated combined stops are avoided.
      xfer(`SPC_OFS_SELECT, 1'b1, 32'hc);
      regen       <= 1'b1;
      target_freq <= 16'h0020;
      ticks(4);
      f = out_freq_q;
      ticks(3);
      chk("both hold", {16'h0, f}, {16'h0, out_freq_q});
      chk("both flux", 32'h1, {31'h0, flux_brake_q});
      @(posedge clock);
      regen <= 1'b0;
      step_chk(16'h0008);
      wait_freq(16'h0020);
      @(posedge clock);
      target_freq <= 16'h0060;
      ticks(3);
      chk("no flux on rise", 32'h0, {31'h0, flux_brake_q});
      @(posedge clock);
      motor_run <= 1'b0;
      ticks(1);
      chk("stop freq", 32'h0, {16'h0, out_freq_q});
      state_chk(2'h0);
      results();
   end
endmodule : testbench
`default_nettype wire
